// [design/iold_port_diag.sv]
`timescale 1ns/1ps
// Overview of operation
// (RL1) l+ to return short: led red, qualifier bit 2, event 0x1806.
// (RL2) aux supply pair short: led red, qualifier bit 2, event 0x180F.
// (RL3) c/q to supply short: led red, qualifier bit 3, 0x1804/0x1813.
// (RL4) io-link, type-compatible, identity differs: flash green, bit 0, 0x1803.
// (RL5) io-link, device pd longer than mapped: flash green, bit 1, 0x1F01.
// (RL6) during length mismatch all in/out pd bytes of port are zero.
// (RL7) io-link mode device lost: flash green, qualifier bit 5, 0x1800.
// (RL8) no device connected: all input pd of the port reads zero.
// (RL9) aux supply drop: aux led off, event 0x180E, no qualifier bit.
// (RL10) only short conditions reach the system diagnostic data.
// (RL11) qualifier bits follow live state; one event per occurrence.
module iold_port_diag (
	input wire logic clk,
	input wire logic rst,
	// detector pins, asynchronous
	input wire logic lplus_short_pin,
	input wire logic aux_short_pin,
	input wire logic cq_lplus_short_pin,
	input wire logic cq_ret_short_pin,
	input wire logic aux_low_pin,
	input wire logic device_present_pin,
	// from the link controller, same clock
	input wire logic [15:0] dev_vendor_id,
	input wire logic [23:0] dev_device_id,
	input wire logic [7:0] dev_pd_len,
	input wire logic [7:0] pd_in_raw,
	input wire logic [7:0] pd_out_raw,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// outputs
	output logic [7:0] port_qualifier_input,
	output logic [1:0] port_led,
	output logic aux_led,
	output logic [7:0] pd_in_out,
	output logic [7:0] pd_out_out,
	output logic supply_short_flag,
	output logic line_short_flag,
	output logic [15:0] event_code,
	output logic event_valid
);
	logic [4:0] pins_s;
	logic [31:0] ctrl_ff;
	logic [15:0] vid_ff;
	logic [23:0] did_ff;
	logic [7:0] pdlen_ff;
	logic [iold_pkg::NCOND-1:0] cond;
	logic [iold_pkg::NCOND-1:0] cond_prev_ff;
	logic [iold_pkg::NCOND-1:0] pend_ff;
	logic [iold_pkg::NCOND-1:0] nxt_pend;
	logic [15:0] sticky_ev_ff;
	logic iolink_mode;
	logic [31:0] flash_cnt_ff;
	logic flash_ff;
	logic [7:0] aw_addr_ff;
	logic aw_have_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;
	logic w_have_ff;
	logic present_meta_ff;
	logic present_ff;
	logic [1:0] ident_cmp_ff;
	logic [1:0] pdlen_cmp_ff;

	function automatic logic [15:0] ev_of(input int idx);
		case (idx)
			iold_pkg::C_LPLUS: ev_of = iold_pkg::EV_LPLUS;
			iold_pkg::C_AUXSHORT: ev_of = iold_pkg::EV_AUXSHORT;
			iold_pkg::C_CQ_LPLUS: ev_of = iold_pkg::EV_CQ_LPLUS;
			iold_pkg::C_CQ_RET: ev_of = iold_pkg::EV_CQ_RET;
			iold_pkg::C_IDENT: ev_of = iold_pkg::EV_IDENT;
			iold_pkg::C_PDLEN: ev_of = iold_pkg::EV_PDLEN;
			iold_pkg::C_LOST: ev_of = iold_pkg::EV_LOST;
			default: ev_of = iold_pkg::EV_AUXDROP;
		endcase
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	// pins are raw detector levels; synchronise before use
	iold_sync #(.W(5)) u_sync (
		.clk(clk),
		.rst(rst),
		.d({aux_low_pin, cq_ret_short_pin, cq_lplus_short_pin,
			lplus_short_pin, aux_short_pin}),
		.q(pins_s)
	);

	assign iolink_mode = ctrl_ff[iold_pkg::CTRL_IOLINK_BIT];

	always_comb begin
		cond = '0;
		cond[iold_pkg::C_LPLUS] = pins_s[1];
		cond[iold_pkg::C_AUXSHORT] = pins_s[0];
		cond[iold_pkg::C_CQ_LPLUS] = pins_s[2];
		cond[iold_pkg::C_CQ_RET] = pins_s[3];
		cond[iold_pkg::C_AUXDROP] = pins_s[4];
		// identity check only when device is there to be read
		cond[iold_pkg::C_IDENT] = iolink_mode
			&& ctrl_ff[iold_pkg::CTRL_TYPECOMP_BIT] && present_ff
			&& ident_cmp_ff[1]; // RL4
		cond[iold_pkg::C_PDLEN] = iolink_mode && present_ff
			&& pdlen_cmp_ff[1]; // RL5
		cond[iold_pkg::C_LOST] = iolink_mode && !present_ff; // RL7
	end
	// compares wait as long as presence, so a pulled device is no mismatch
	always_ff @(posedge clk) begin
		if (rst) begin
			present_meta_ff <= 1'b0;
			present_ff <= 1'b0;
			ident_cmp_ff <= 2'b00;
			pdlen_cmp_ff <= 2'b00;
		end else begin
			present_meta_ff <= device_present_pin;
			present_ff <= present_meta_ff;
			ident_cmp_ff <= {ident_cmp_ff[0], ((dev_vendor_id != vid_ff)
				|| (dev_device_id != did_ff))};
			pdlen_cmp_ff <= {pdlen_cmp_ff[0], (dev_pd_len > pdlen_ff)};
		end
	end

	// qualifier bits track the live condition
	always_ff @(posedge clk) begin
		if (rst) begin
			port_qualifier_input <= 8'h00;
		end else begin
			port_qualifier_input <= 8'h00;
			port_qualifier_input[iold_pkg::QUAL_SUPPLY_BIT] <=
				cond[iold_pkg::C_LPLUS] | cond[iold_pkg::C_AUXSHORT]; // RL1 RL2
			port_qualifier_input[iold_pkg::QUAL_LINE_BIT] <=
				cond[iold_pkg::C_CQ_LPLUS] | cond[iold_pkg::C_CQ_RET]; // RL3
			port_qualifier_input[iold_pkg::QUAL_IDENT_BIT] <=
				cond[iold_pkg::C_IDENT]; // RL4
			port_qualifier_input[iold_pkg::QUAL_PDLEN_BIT] <=
				cond[iold_pkg::C_PDLEN]; // RL5
			port_qualifier_input[iold_pkg::QUAL_LINK_BIT] <=
				cond[iold_pkg::C_LOST]; // RL7 RL11
		end
	end

	// only shorts go to the system diagnostic flags
	always_ff @(posedge clk) begin
		if (rst) begin
			supply_short_flag <= 1'b0;
			line_short_flag <= 1'b0;
		end else begin
			supply_short_flag <= cond[iold_pkg::C_LPLUS]
				| cond[iold_pkg::C_AUXSHORT]; // RL10
			line_short_flag <= cond[iold_pkg::C_CQ_LPLUS]
				| cond[iold_pkg::C_CQ_RET]; // RL10
		end
	end

	// flash timebase
	always_ff @(posedge clk) begin
		if (rst) begin
			flash_cnt_ff <= 32'h0000_0000;
			flash_ff <= 1'b0;
		end else if (flash_cnt_ff == 32'(iold_pkg::FLASH_CYCLES - 1)) begin
			flash_cnt_ff <= 32'h0000_0000;
			flash_ff <= ~flash_ff;
		end else begin
			flash_cnt_ff <= flash_cnt_ff + 32'h0000_0001;
		end
	end

	// red outranks flashing green
	always_ff @(posedge clk) begin
		if (rst) begin
			port_led <= iold_pkg::LED_OFF;
			aux_led <= 1'b0;
		end else begin
			if (|cond[iold_pkg::C_CQ_RET:iold_pkg::C_LPLUS]) begin
				port_led <= iold_pkg::LED_RED; // RL1 RL2 RL3
			end else if (cond[iold_pkg::C_IDENT] | cond[iold_pkg::C_PDLEN]
				| cond[iold_pkg::C_LOST]) begin
				port_led <= flash_ff ? iold_pkg::LED_GREEN
					: iold_pkg::LED_OFF; // RL4 RL5 RL7
			end else if (iolink_mode) begin
				port_led <= iold_pkg::LED_GREEN;
			end else begin
				port_led <= iold_pkg::LED_OFF;
			end
			aux_led <= !cond[iold_pkg::C_AUXDROP]; // RL9
		end
	end

	// process data gating
	always_ff @(posedge clk) begin
		if (rst) begin
			pd_in_out <= 8'h00;
			pd_out_out <= 8'h00;
		end else begin
			pd_in_out <= (cond[iold_pkg::C_PDLEN] || !present_ff)
				? 8'h00 : pd_in_raw; // RL6 RL8
			pd_out_out <= cond[iold_pkg::C_PDLEN] ? 8'h00 : pd_out_raw; // RL6
		end
	end

	// rising edge of each condition queues one event; lowest index first
	always_comb begin
		nxt_pend = pend_ff | (cond & ~cond_prev_ff); // RL11
		for (int i = iold_pkg::NCOND - 1; i >= 0; i--) begin
			if (pend_ff[i] && !(|(pend_ff & ((8'h01 << i) - 8'h01)))) begin
				nxt_pend[i] = cond[i] & ~cond_prev_ff[i];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cond_prev_ff <= '0;
			pend_ff <= '0;
			event_valid <= 1'b0;
			event_code <= 16'h0000;
			sticky_ev_ff <= 16'h0000;
		end else begin
			cond_prev_ff <= cond;
			pend_ff <= nxt_pend;
			event_valid <= |pend_ff;
			for (int i = iold_pkg::NCOND - 1; i >= 0; i--) begin
				if (pend_ff[i]) begin
					event_code <= ev_of(i); // RL9 RL11
					sticky_ev_ff <= ev_of(i);
				end
			end
		end
	end

	// axi4-lite write path
	always_ff @(posedge clk) begin
		if (rst) begin
			aw_have_ff <= 1'b0;
			w_have_ff <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_data_ff <= 32'h0000_0000;
			w_strb_ff <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= iold_pkg::RESP_OKAY;
			ctrl_ff <= iold_pkg::CTRL_RESET;
			vid_ff <= iold_pkg::VID_RESET;
			did_ff <= iold_pkg::DID_RESET;
			pdlen_ff <= iold_pkg::PDLEN_RESET;
		end else begin
			s_axi_awready <= !aw_have_ff && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready <= !w_have_ff && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (aw_have_ff && w_have_ff && !s_axi_bvalid) begin
				aw_have_ff <= 1'b0;
				w_have_ff <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= iold_pkg::RESP_OKAY;
				case (aw_addr_ff)
					iold_pkg::ADDR_CTRL:
						ctrl_ff <= merge(ctrl_ff, w_data_ff, w_strb_ff) & 32'h0000_0003;
					iold_pkg::ADDR_VID:
						vid_ff <= 16'(merge({16'h0000, vid_ff}, w_data_ff, w_strb_ff));
					iold_pkg::ADDR_DID:
						did_ff <= 24'(merge({8'h00, did_ff}, w_data_ff, w_strb_ff));
					iold_pkg::ADDR_PDLEN:
						pdlen_ff <= 8'(merge({24'h0, pdlen_ff}, w_data_ff, w_strb_ff));
					iold_pkg::ADDR_COND, iold_pkg::ADDR_QUAL,
					iold_pkg::ADDR_EVENT, iold_pkg::ADDR_SYSDIAG: ;
					default: s_axi_bresp <= iold_pkg::RESP_SLVERR;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// axi4-lite read path
	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= iold_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= iold_pkg::RESP_OKAY;
				case (s_axi_araddr)
					iold_pkg::ADDR_CTRL: s_axi_rdata <= ctrl_ff;
					iold_pkg::ADDR_COND: s_axi_rdata <= {24'h0, cond};
					iold_pkg::ADDR_QUAL:
						s_axi_rdata <= {24'h0, port_qualifier_input};
					iold_pkg::ADDR_EVENT: s_axi_rdata <= {16'h0, sticky_ev_ff};
					iold_pkg::ADDR_SYSDIAG: s_axi_rdata <=
						{30'h0, line_short_flag, supply_short_flag};
					iold_pkg::ADDR_VID: s_axi_rdata <= {16'h0, vid_ff};
					iold_pkg::ADDR_DID: s_axi_rdata <= {8'h0, did_ff};
					iold_pkg::ADDR_PDLEN: s_axi_rdata <= {24'h0, pdlen_ff};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= iold_pkg::RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// [design/iold_pkg.sv]
package iold_pkg;
	// AXI4-Lite register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_COND = 8'h04;
	localparam logic [7:0] ADDR_QUAL = 8'h08;
	localparam logic [7:0] ADDR_EVENT = 8'h0C;
	localparam logic [7:0] ADDR_SYSDIAG = 8'h10;
	localparam logic [7:0] ADDR_VID = 8'h14;
	localparam logic [7:0] ADDR_DID = 8'h18;
	localparam logic [7:0] ADDR_PDLEN = 8'h1C;
	// control register fields
	localparam int CTRL_IOLINK_BIT = 0;
	localparam int CTRL_TYPECOMP_BIT = 1;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [15:0] VID_RESET = 16'h0000;
	localparam logic [23:0] DID_RESET = 24'h00_0000;
	localparam logic [7:0] PDLEN_RESET = 8'h00;
	// qualifier bit positions
	localparam int QUAL_IDENT_BIT = 0;
	localparam int QUAL_PDLEN_BIT = 1;
	localparam int QUAL_SUPPLY_BIT = 2;
	localparam int QUAL_LINE_BIT = 3;
	localparam int QUAL_LINK_BIT = 5;
	// condition indices
	localparam int NCOND = 8;
	localparam int C_LPLUS = 0;
	localparam int C_AUXSHORT = 1;
	localparam int C_CQ_LPLUS = 2;
	localparam int C_CQ_RET = 3;
	localparam int C_IDENT = 4;
	localparam int C_PDLEN = 5;
	localparam int C_LOST = 6;
	localparam int C_AUXDROP = 7;
	// event codes
	localparam logic [15:0] EV_LPLUS = 16'h1806;
	localparam logic [15:0] EV_AUXSHORT = 16'h180F;
	localparam logic [15:0] EV_CQ_LPLUS = 16'h1804;
	localparam logic [15:0] EV_CQ_RET = 16'h1813;
	localparam logic [15:0] EV_IDENT = 16'h1803;
	localparam logic [15:0] EV_PDLEN = 16'h1F01;
	localparam logic [15:0] EV_LOST = 16'h1800;
	localparam logic [15:0] EV_AUXDROP = 16'h180E;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		LED_OFF = 2'b00,
		LED_GREEN = 2'b01,
		LED_GREEN_FLASH = 2'b10,
		LED_RED = 2'b11
	} iold_led_type;
	localparam int FLASH_TIME_MS = 250;
	localparam int CLK_MHZ = 100;
	localparam int FLASH_CYCLES = FLASH_TIME_MS * 1000 * CLK_MHZ;
endpackage

// [design/iold_sync.sv]
`timescale 1ns/1ps
// two-stage synchroniser for a vector of pin levels
module iold_sync #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_ff;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_ff <= '0;
			q <= '0;
		end else begin
			meta_ff <= d;
			q <= meta_ff;
		end
	end
endmodule

// [tb/iold_diag_checker.sv]
`timescale 1ns/1ps
module iold_diag_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic lplus_short_pin,
	input wire logic aux_short_pin,
	input wire logic cq_lplus_short_pin,
	input wire logic cq_ret_short_pin,
	input wire logic aux_low_pin,
	input wire logic device_present_pin,
	input wire logic [7:0] port_qualifier_input,
	input wire logic [1:0] port_led,
	input wire logic aux_led,
	input wire logic [7:0] pd_in_out,
	input wire logic [7:0] pd_out_out,
	input wire logic supply_short_flag,
	input wire logic line_short_flag,
	input wire logic [15:0] event_code,
	input wire logic event_valid
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// cycles since the last short pin, saturating
	logic [3:0] calm_ff;
	logic any_short;
	assign any_short = lplus_short_pin | aux_short_pin | cq_lplus_short_pin
		| cq_ret_short_pin;
	always_ff @(posedge clk) begin
		if (rst || any_short)
			calm_ff <= 4'h0;
		else if (calm_ff != 4'hF)
			calm_ff <= calm_ff + 4'h1;
	end
	sequence seq_line_short;
		$rose(cq_lplus_short_pin) ##1 cq_lplus_short_pin [*2];
	endsequence
	sequence seq_red_shown;
		##[0:4] port_led == 2'b11;
	endsequence
	chk_supply_qual: assert property ($rose(lplus_short_pin) |->
		##[2:6] port_qualifier_input[2]) else $error("supply bit missing");
	chk_aux_short: assert property ($rose(aux_short_pin) |->
		##[2:6] (port_qualifier_input[2] && supply_short_flag))
		else $error("aux short not shown");
	chk_line_qual: assert property ($rose(cq_ret_short_pin) |->
		##[2:6] (port_qualifier_input[3] && line_short_flag))
		else $error("line short not shown");
	chk_red_led: assert property (seq_line_short |-> seq_red_shown)
		else $error("led not red on line short");
	chk_pd_zero: assert property (port_qualifier_input[1] &&
		$past(port_qualifier_input[1]) |-> pd_in_out == 8'h00 &&
		pd_out_out == 8'h00) else $error("pd not zeroed");
	chk_absent_zero: assert property (!device_present_pin [*6] |->
		pd_in_out == 8'h00) else $error("pd shown without device");
	chk_aux_event: assert property ($rose(aux_low_pin) |->
		##[2:8] (event_valid && event_code == 16'h180E))
		else $error("aux drop event missing");
	chk_aux_led: assert property (aux_low_pin [*5] |-> !aux_led &&
		port_qualifier_input == 8'h00) else $error("aux drop display wrong");
	chk_sys_short: assert property ((supply_short_flag || line_short_flag)
		|-> calm_ff < 4'h8) else $error("sysdiag without short");
	chk_qual_clear: assert property ($fell(lplus_short_pin) &&
		!aux_short_pin |-> ##[2:6] !port_qualifier_input[2])
		else $error("supply bit stuck");
endmodule

// [tb/iold_dev_model.sv]
`timescale 1ns/1ps
module iold_dev_model #(
	parameter logic [15:0] VID = 16'h0001,
	parameter logic [23:0] DID = 24'h00_0001,
	parameter logic [7:0] PDLEN = 8'h04
) (
	input wire logic clk,
	input wire logic plugged,
	input wire logic wrong_id,
	input wire logic long_pd,
	output logic present,
	output logic [15:0] vendor_id,
	output logic [23:0] device_id,
	output logic [7:0] pd_len,
	output logic [7:0] pd_data
);
	logic [7:0] cnt_ff = 8'h00;
	always @(posedge clk) cnt_ff <= cnt_ff + 8'h01;
	assign present = plugged;
	// unplugged lines float: show a pattern that keeps moving
	assign vendor_id = !plugged ? {cnt_ff, ~cnt_ff} : wrong_id ? ~VID : VID;
	assign device_id = plugged ? DID : {3{cnt_ff}};
	assign pd_len = !plugged ? ~cnt_ff : long_pd ? PDLEN + 8'h01 : PDLEN;
	assign pd_data = plugged ? (8'hC2 | {7'h00, cnt_ff[0]}) : ~cnt_ff;
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	typedef struct {logic [4:0] pins; logic [7:0] qual; logic [15:0] ev;
		logic [1:0] sys;} iold_row_type;
	localparam logic [15:0] DEV_VID = 16'h5A5A; // arbitrary value
	localparam logic [23:0] DEV_DID = 24'h00_0A5C; // arbitrary value
	logic clk, rst, plugged, wrong_id, long_pd, device_present_pin;
	logic [4:0] pins;
	logic [7:0] s_axi_awaddr, s_axi_araddr, pd_out_raw, dev_pd_len, pd_in_raw;
	logic [7:0] port_qualifier_input, pd_in_out, pd_out_out;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, port_led, resp;
	logic [15:0] dev_vendor_id, event_code;
	logic [23:0] dev_device_id;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, aux_led, event_valid;
	logic supply_short_flag, line_short_flag;
	logic [15:0] evq[$];
	int errors, comparisons;
	iold_row_type rows[5] = '{'{5'h01, 8'h04, 16'h1806, 2'h1},
		'{5'h02, 8'h04, 16'h180F, 2'h1}, '{5'h04, 8'h08, 16'h1804, 2'h2},
		'{5'h08, 8'h08, 16'h1813, 2'h2}, '{5'h10, 8'h00, 16'h180E, 2'h0}};
	iold_port_diag dut_u (.clk, .rst, .lplus_short_pin(pins[0]),
		.aux_short_pin(pins[1]), .cq_lplus_short_pin(pins[2]),
		.cq_ret_short_pin(pins[3]), .aux_low_pin(pins[4]), .device_present_pin,
		.dev_vendor_id, .dev_device_id, .dev_pd_len, .pd_in_raw, .pd_out_raw,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.port_qualifier_input, .port_led, .aux_led, .pd_in_out, .pd_out_out,
		.supply_short_flag, .line_short_flag, .event_code, .event_valid);
	iold_dev_model #(.VID(DEV_VID), .DID(DEV_DID), .PDLEN(8'h04)) dev_u (
		.clk, .plugged, .wrong_id, .long_pd, .present(device_present_pin),
		.vendor_id(dev_vendor_id), .device_id(dev_device_id),
		.pd_len(dev_pd_len), .pd_data(pd_in_raw));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// events are one-cycle pulses, so sample mid-cycle
	always @(negedge clk) if (event_valid === 1'b1) evq.push_back(event_code);
	task automatic chk(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic chk_ev(input logic [15:0] exp);
		chk("event_count", 32'h1, evq.size());
		chk("event_code", {16'h0000, exp}, {16'h0000, evq[0]});
		evq.delete();
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic aw, w, b;
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		b = 1'b0;
		for (n = 0; n < 100 && !b; n++) begin
			@(negedge clk);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid && s_axi_bready;
			resp = s_axi_bresp;
			@(posedge clk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		if (!b) errors++;
		#1;
	endtask
	task automatic axr(input logic [7:0] a);
		logic ar, r;
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		r = 1'b0;
		for (n = 0; n < 100 && !r; n++) begin
			@(negedge clk);
			ar = s_axi_arvalid && s_axi_arready;
			r = s_axi_rvalid && s_axi_rready;
			rd = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge clk);
			if (ar) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		if (!r) errors++;
		#1;
	endtask
	task automatic give_verdict;
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		give_verdict;
	end
	initial begin
		{rst, plugged} = 2'b11;
		{pins, wrong_id, long_pd, s_axi_awvalid, s_axi_wvalid} = 9'h000;
		{s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hF;
		pd_out_raw = 8'h96;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		idle(4);
		foreach (rows[i]) begin
			evq.delete();
			pins <= rows[i].pins;
			idle(12);
			chk("qualifier", rows[i].qual, port_qualifier_input);
			chk("sysdiag", rows[i].sys, {line_short_flag, supply_short_flag});
			chk_ev(rows[i].ev);
			if (rows[i].sys != 2'h0) chk("led", 2'b11, port_led);
			else chk("aux_led", 1'b0, aux_led);
			pins <= 5'h00;
			idle(12);
			chk("qual_clear", 8'h00, port_qualifier_input);
		end
		rst <= 1'b1;
		idle(3);
		rst <= 1'b0;
		idle(2);
		axr(iold_pkg::ADDR_CTRL);
		chk("ctrl_reset", iold_pkg::CTRL_RESET, rd);
		axr(iold_pkg::ADDR_VID);
		chk("vid_reset", {16'h0000, iold_pkg::VID_RESET}, rd);
		axw(iold_pkg::ADDR_CTRL, 32'h0000_0003);
		axw(iold_pkg::ADDR_VID, {16'h0000, DEV_VID});
		axw(iold_pkg::ADDR_DID, {8'h00, DEV_DID});
		axw(iold_pkg::ADDR_PDLEN, 32'h0000_0004);
		idle(12);
		evq.delete();
		wrong_id <= 1'b1;
		idle(12);
		chk("ident_qual", 8'h01, port_qualifier_input);
		chk_ev(16'h1803);
		chk("ident_led", 1'b0, port_led[1]);
		chk("ident_sys", 2'h0, {line_short_flag, supply_short_flag});
		axw(iold_pkg::ADDR_CTRL, 32'h0000_0001);
		idle(12);
		chk("ident_off", 8'h00, port_qualifier_input);
		wrong_id <= 1'b0;
		axw(iold_pkg::ADDR_CTRL, 32'h0000_0003);
		idle(12);
		evq.delete();
		long_pd <= 1'b1;
		idle(12);
		chk("pdlen_qual", 8'h02, port_qualifier_input);
		chk_ev(16'h1F01);
		chk("pd_in_zero", 8'h00, pd_in_out);
		chk("pd_out_zero", 8'h00, pd_out_out);
		long_pd <= 1'b0;
		idle(12);
		chk("pd_out_pass", 8'h96, pd_out_out);
		evq.delete();
		plugged <= 1'b0;
		idle(12);
		chk("lost_qual", 8'h20, port_qualifier_input);
		chk_ev(16'h1800);
		chk("lost_pd", 8'h00, pd_in_out);
		chk("lost_led", 1'b0, port_led[1]);
		axr(iold_pkg::ADDR_EVENT);
		chk("last_event", 32'h0000_1800, rd);
		plugged <= 1'b1;
		idle(12);
		chk("relink", 8'h00, port_qualifier_input);
		chk("relink_led", 2'b01, port_led);
		chk("pd_in_pass", 8'hC2, {pd_in_out[7:1], 1'b0});
		chk("aux_led_ok", 1'b1, aux_led);
		axr(8'h40);
		chk("unmapped_resp", iold_pkg::RESP_SLVERR, resp);
		chk("unmapped_data", 32'h0, rd);
		axw(iold_pkg::ADDR_QUAL, 32'h0000_00FF);
		chk("ro_resp", iold_pkg::RESP_OKAY, resp);
		axr(iold_pkg::ADDR_QUAL);
		chk("ro_kept", 32'h0, rd);
		axw(8'h40, 32'h0000_0000);
		chk("unmapped_wr", iold_pkg::RESP_SLVERR, resp);
		s_axi_wstrb <= 4'h0;
		axw(iold_pkg::ADDR_VID, 32'h0000_0000);
		s_axi_wstrb <= 4'hF;
		axr(iold_pkg::ADDR_VID);
		chk("strb_kept", {16'h0000, DEV_VID}, rd);
		give_verdict;
	end
endmodule
bind iold_port_diag iold_diag_checker chk_u (.clk, .rst, .lplus_short_pin,
	.aux_short_pin, .cq_lplus_short_pin, .cq_ret_short_pin, .aux_low_pin,
	.device_present_pin, .port_qualifier_input, .port_led, .aux_led,
	.pd_in_out, .pd_out_out, .supply_short_flag, .line_short_flag,
	.event_code, .event_valid);
